// file: core/pg_pkg.sv
package pg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] password_offset = 8'h0b;
  localparam logic [7:0] good_status_offset = 8'h0c;
  localparam logic [7:0] power_good_control_offset = 8'h0d;
  localparam logic [7:0] buck1_control_offset = 8'h0e;

  localparam logic [7:0] unlock_key_value = 8'h7d;
  localparam logic [7:0] password_reset = 8'h00;
  localparam logic [7:0] power_good_control_reset = 8'h0c;
  localparam logic [7:0] buck1_control_reset = 8'h18;
  localparam logic [7:0] unmapped_read_value = 8'h00;

  // field positions
  localparam int first_mask_bit = 3;
  localparam int second_mask_bit = 2;
  localparam int first_status_bit = 1;
  localparam int second_status_bit = 0;
  localparam int external_adjust_bit = 7;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] spare;
    logic first_ldo_good_mask;
    logic second_ldo_good_mask;
    logic [1:0] good_output_delay_sel;
  } power_good_control_type;

  typedef struct packed {
    logic buck_one_external_adjust;
    logic spare;
    logic [5:0] buck_one_voltage_code;
  } buck1_control_type;

  typedef enum logic [1:0] {
    delay_20ms,
    delay_100ms,
    delay_200ms,
    delay_400ms
  } delay_sel_type;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint clock_hz = 40_000_000;
  localparam longint delay_20_ms = 20;
  localparam longint delay_100_ms = 100;
  localparam longint delay_200_ms = 200;
  localparam longint delay_400_ms = 400;
  localparam longint delay_20_cycles = delay_20_ms * clock_hz / 1000;
  localparam longint delay_100_cycles = delay_100_ms * clock_hz / 1000;
  localparam longint delay_200_cycles = delay_200_ms * clock_hz / 1000;
  localparam longint delay_400_cycles = delay_400_ms * clock_hz / 1000;
  localparam int delay_count_width = 24;

  // voltage table, millivolts
  localparam int mv_width = 12;
  localparam int fine_base_mv = 900;
  localparam int fine_step_mv = 25;
  localparam int fine_last_code = 24;
  localparam int mid_base_mv = 1500;
  localparam int mid_step_mv = 50;
  localparam int mid_last_code = 52;
  localparam int coarse_base_mv = 2900;
  localparam int coarse_step_mv = 100;
  localparam int coarse_last_code = 56;
  localparam int top_mv = 3300;

endpackage : pg_pkg

// file: core/good_delay_timer.sv
module good_delay_timer
  import pg_pkg::*;
#(
  parameter logic [delay_count_width-1:0] cycles_20 =
    delay_count_width'(delay_20_cycles),
  parameter logic [delay_count_width-1:0] cycles_100 =
    delay_count_width'(delay_100_cycles),
  parameter logic [delay_count_width-1:0] cycles_200 =
    delay_count_width'(delay_200_cycles),
  parameter logic [delay_count_width-1:0] cycles_400 =
    delay_count_width'(delay_400_cycles)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic all_good,
  input wire logic [1:0] delay_sel,
  output logic released
);

  logic [delay_count_width-1:0] count;
  logic [delay_count_width-1:0] limit;

  always_comb begin
    case (delay_sel_type'(delay_sel))
      delay_20ms: limit = cycles_20;
      delay_100ms: limit = cycles_100;
      delay_200ms: limit = cycles_200;
      delay_400ms: limit = cycles_400;
      default: limit = cycles_400;
    endcase
  end

  // a drop restarts the wait from zero, so glitches never shorten it
  always_ff @(posedge clk) begin
    if (rst || !all_good) begin
      count <= '0;
      released <= 1'b0;
    end else if (count >= limit - 1'b1) begin
      released <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end

endmodule : good_delay_timer

// file: core/power_good_and_buck1_config.sv
module power_good_and_buck1_config
  import pg_pkg::*;
#(
  parameter logic [delay_count_width-1:0] cycles_20 =
    delay_count_width'(delay_20_cycles),
  parameter logic [delay_count_width-1:0] cycles_100 =
    delay_count_width'(delay_100_cycles),
  parameter logic [delay_count_width-1:0] cycles_200 =
    delay_count_width'(delay_200_cycles),
  parameter logic [delay_count_width-1:0] cycles_400 =
    delay_count_width'(delay_400_cycles)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_write_refused,
  input wire logic first_ldo_in_regulation,
  input wire logic second_ldo_in_regulation,
  output logic power_good_out,
  output logic power_good_out_oe,
  output logic buck_one_external_adjust,
  output logic [5:0] buck_one_voltage_code,
  output logic [mv_width-1:0] buck_one_target_mv
);

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [mv_width-1:0] code_to_mv(input logic [5:0] code);
    int c;
    int mv;
    c = int'(code);
    if (c <= fine_last_code) begin
      mv = fine_base_mv + fine_step_mv * c;
    end else if (c <= mid_last_code) begin
      mv = mid_base_mv + mid_step_mv * (c - fine_last_code);
    end else if (c <= coarse_last_code) begin
      mv = coarse_base_mv + coarse_step_mv * (c - mid_last_code);
    end else begin
      mv = top_mv;
    end
    return mv[mv_width-1:0];
  endfunction : code_to_mv

  function automatic logic is_protected(input logic [7:0] addr);
    return (addr == power_good_control_offset)
        || (addr == buck1_control_offset);
  endfunction : is_protected

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] unlock_key;
  power_good_control_type power_good_control;
  buck1_control_type buck1_control;
  logic transaction;
  logic unlocked;
  logic write_allowed;
  logic key_write;
  logic control_write;
  logic buck_write;

  // the key is judged as it stands before this transaction lands
  assign transaction = reg_write || reg_read;
  assign unlocked = (unlock_key == unlock_key_value);
  assign write_allowed = reg_write && unlocked;
  assign key_write = reg_write && (reg_addr == password_offset);
  assign control_write = write_allowed
      && (reg_addr == power_good_control_offset);
  assign buck_write = write_allowed && (reg_addr == buck1_control_offset);

  // any transaction consumes the key; a password write then reloads it
  always_ff @(posedge clk) begin
    if (rst) begin
      unlock_key <= password_reset;
    end else if (key_write) begin
      unlock_key <= reg_wdata;
    end else if (transaction) begin
      unlock_key <= password_reset;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      power_good_control <= power_good_control_reset;
    end else if (control_write) begin
      power_good_control <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buck1_control <= buck1_control_reset;
    end else if (buck_write) begin
      buck1_control <= reg_wdata;
    end
  end

  // flags a protected write dropped for lack of an unlock
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_write_refused <= 1'b0;
    end else begin
      reg_write_refused <= reg_write && is_protected(reg_addr) && !unlocked;
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  logic [7:0] status_byte;
  logic [7:0] next_rdata;

  // only the two regulator flags of this block live in the status byte
  always_comb begin
    status_byte = unmapped_read_value;
    status_byte[first_status_bit] = first_ldo_in_regulation;
    status_byte[second_status_bit] = second_ldo_in_regulation;
  end

  always_comb begin
    next_rdata = unmapped_read_value;
    case (reg_addr)
      password_offset: next_rdata = unlock_key;
      good_status_offset: next_rdata = status_byte;
      power_good_control_offset: next_rdata = power_good_control;
      buck1_control_offset: next_rdata = buck1_control;
      default: next_rdata = unmapped_read_value;
    endcase
  end

  // read data holds until the next read, so a slow host may fetch late
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= unmapped_read_value;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // power-good pin
  // ----------------------------------------------------------------
  logic [1:0] in_regulation;
  logic [1:0] good_mask;
  logic [1:0] flag_ok;
  logic all_good;
  logic released;

  assign in_regulation = {first_ldo_in_regulation, second_ldo_in_regulation};
  assign good_mask = {power_good_control.first_ldo_good_mask,
      power_good_control.second_ldo_good_mask};

  // a set mask bit takes its regulator out of the decision
  for (genvar i = 0; i < 2; i++) begin : g_flag
    assign flag_ok[i] = good_mask[i] || in_regulation[i];
  end
  assign all_good = &flag_ok;

  good_delay_timer #(
    .cycles_20(cycles_20),
    .cycles_100(cycles_100),
    .cycles_200(cycles_200),
    .cycles_400(cycles_400)
  ) delay_timer (
    .clk(clk),
    .rst(rst),
    .all_good(all_good),
    .delay_sel(power_good_control.good_output_delay_sel),
    .released(released)
  );

  // open drain: pin driven low while oe is high, data bit fixed low
  always_ff @(posedge clk) begin
    if (rst) begin
      power_good_out <= 1'b0;
    end else begin
      power_good_out <= 1'b0;
    end
  end

  // all_good gates the release directly so a dropping flag pulls the pin
  // low one cycle later, without waiting for the timer
  always_ff @(posedge clk) begin
    if (rst) begin
      power_good_out_oe <= 1'b1;
    end else begin
      power_good_out_oe <= !(released && all_good);
    end
  end

  // ----------------------------------------------------------------
  // buck one outputs
  // ----------------------------------------------------------------
  // outputs lag the register by one cycle so every pin leaves a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      buck_one_external_adjust <= 1'b0;
    end else begin
      buck_one_external_adjust <= buck1_control.buck_one_external_adjust;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buck_one_voltage_code <= '0;
    end else begin
      buck_one_voltage_code <= buck1_control.buck_one_voltage_code;
    end
  end

  // code is meaningless under external adjustment, so report zero
  always_ff @(posedge clk) begin
    if (rst) begin
      buck_one_target_mv <= '0;
    end else if (buck1_control.buck_one_external_adjust) begin
      buck_one_target_mv <= '0;
    end else begin
      buck_one_target_mv <= code_to_mv(buck1_control.buck_one_voltage_code);
    end
  end

endmodule : power_good_and_buck1_config

// file: bench/host_model.sv
module host_model (
  input wire logic clk,
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // request stays up until the caller idles: back to back costs nothing
  task automatic xfer(input logic wr, input logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    reg_write = wr;
    reg_read = !wr;
    reg_addr = a;
    reg_wdata = d;
  endtask : xfer
  task automatic idle();
    @(negedge clk);
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask : idle
endmodule : host_model

// file: bench/pg_monitor.sv
module pg_monitor
  import pg_pkg::*;
#(
  parameter logic [delay_count_width-1:0] cycles_20 =
    delay_count_width'(delay_20_cycles),
  parameter logic [delay_count_width-1:0] cycles_100 =
    delay_count_width'(delay_100_cycles),
  parameter logic [delay_count_width-1:0] cycles_200 =
    delay_count_width'(delay_200_cycles),
  parameter logic [delay_count_width-1:0] cycles_400 =
    delay_count_width'(delay_400_cycles)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_write_refused,
  input wire logic first_ldo_in_regulation,
  input wire logic second_ldo_in_regulation,
  input wire logic power_good_out_oe,
  input wire logic buck_one_external_adjust,
  input wire logic [5:0] buck_one_voltage_code,
  input wire logic [mv_width-1:0] buck_one_target_mv
);
  // ----
  // shadow state
  // ----
  logic key_armed;
  logic [7:0] pgc;
  logic [delay_count_width-1:0] good_cnt;
  logic [delay_count_width-1:0] lim;
  logic good;
  logic prot;
  assign prot = reg_addr == 8'h0d || reg_addr == 8'h0e;
  assign good = (pgc[3] | first_ldo_in_regulation) &
                (pgc[2] | second_ldo_in_regulation);
  assign lim = pgc[1:0] == 2'h0 ? cycles_20 : pgc[1:0] == 2'h1 ? cycles_100 :
               pgc[1:0] == 2'h2 ? cycles_200 : cycles_400;
  always_ff @(posedge clk) begin
    if (rst) key_armed <= 1'b0;
    else if (reg_write | reg_read) key_armed <= reg_write &&
      reg_addr == 8'h0b && reg_wdata == 8'h7d;
  end
  always_ff @(posedge clk) begin
    if (rst) pgc <= 8'h0c;
    else if (reg_write && key_armed && reg_addr == 8'h0d) pgc <= reg_wdata;
  end
  // only the run length counts; a drop restarts it
  always_ff @(posedge clk) begin
    if (rst || !good) good_cnt <= '0;
    else good_cnt <= good_cnt + 1'b1;
  end
  function automatic int mv(input logic [5:0] c);
    if (c <= 6'h18) return 900 + 25 * c;
    if (c <= 6'h34) return 1500 + 50 * (c - 24);
    if (c <= 6'h38) return 2900 + 100 * (c - 52);
    return 3300;
  endfunction : mv
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_unlock;
    reg_write && reg_addr == 8'h0b && reg_wdata == 8'h7d;
  endsequence
  sequence s_consume;
    (reg_write || reg_read) && !(reg_write && reg_addr == 8'h0b);
  endsequence
  property p_key_clear;
    s_unlock ##1 s_consume ##1 (reg_read && reg_addr == 8'h0b)
      |=> reg_rdata == 8'h00;
  endproperty
  property p_refuse;
    reg_write && prot && !key_armed |=> reg_write_refused;
  endproperty
  property p_refuse_cause;
    reg_write_refused |-> $past(reg_write && prot && !key_armed);
  endproperty
  property p_buck_copy;
    reg_write && key_armed && reg_addr == 8'h0e |=> ##1
      {buck_one_external_adjust, buck_one_voltage_code} ==
      {$past(reg_wdata[7], 2), $past(reg_wdata[5:0], 2)};
  endproperty
  property p_voltage;
    (!buck_one_external_adjust && $stable(buck_one_voltage_code))[*3]
      |-> int'(buck_one_target_mv) == mv(buck_one_voltage_code);
  endproperty
  property p_ext_mv;
    buck_one_external_adjust[*3] |-> buck_one_target_mv == '0;
  endproperty
  property p_pg_drop;
    !good |-> ##[1:2] power_good_out_oe;
  endproperty
  property p_pg_early;
    $fell(power_good_out_oe) |-> good_cnt >= lim;
  endproperty
  a_key_clear: assert property (p_key_clear) else $error("key kept");
  a_refuse: assert property (p_refuse) else $error("no refusal");
  a_refuse_cause: assert property (p_refuse_cause)
    else $error("spurious refusal");
  a_buck_copy: assert property (p_buck_copy) else $error("buck");
  a_voltage: assert property (p_voltage) else $error("target mv");
  a_ext_mv: assert property (p_ext_mv) else $error("ext mv");
  a_pg_drop: assert property (p_pg_drop)
    else $error("pin not pulled low");
  a_pg_early: assert property (p_pg_early)
    else $error("pin released early");
endmodule : pg_monitor

bind power_good_and_buck1_config pg_monitor #(.cycles_20(cycles_20),
  .cycles_100(cycles_100), .cycles_200(cycles_200), .cycles_400(cycles_400))
  pg_monitor_i (.clk(clk), .rst(rst), .reg_write(reg_write),
  .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_write_refused(reg_write_refused),
  .first_ldo_in_regulation(first_ldo_in_regulation),
  .second_ldo_in_regulation(second_ldo_in_regulation),
  .power_good_out_oe(power_good_out_oe),
  .buck_one_external_adjust(buck_one_external_adjust),
  .buck_one_voltage_code(buck_one_voltage_code),
  .buck_one_target_mv(buck_one_target_mv));

// file: bench/tb_power_good_and_buck1_config.sv
`define chk(n, s, e) begin total_checks++; if ((s) !== (e)) begin \
  bad_count++; $display("Error %s expected %0h seen %0h", n, e, s); end end
module tb_power_good_and_buck1_config
  import pg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_write, reg_read, reg_write_refused, power_good_out;
  logic power_good_out_oe, buck_one_external_adjust;
  logic first_ldo_in_regulation, second_ldo_in_regulation;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [5:0] buck_one_voltage_code;
  logic [mv_width-1:0] buck_one_target_mv;
  int pw = 0, r0d = 8'h0c, r0e = 8'h18, lim, bad_count, total_checks;
  logic [7:0] adr[5] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h3f};
  logic [7:0] keys[4] = '{8'h00, 8'h7c, 8'h7e, 8'hff};
  power_good_and_buck1_config #(.cycles_20(24'h00000a),
    .cycles_100(24'h000014), .cycles_200(24'h000028),
    .cycles_400(24'h000050)) power_good_and_buck1_config_i (
    .clk(clk), .rst(rst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_write_refused(reg_write_refused),
    .first_ldo_in_regulation(first_ldo_in_regulation),
    .second_ldo_in_regulation(second_ldo_in_regulation),
    .power_good_out(power_good_out), .power_good_out_oe(power_good_out_oe),
    .buck_one_external_adjust(buck_one_external_adjust),
    .buck_one_voltage_code(buck_one_voltage_code),
    .buck_one_target_mv(buck_one_target_mv));
  host_model host_model_i (.clk(clk), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  initial forever #12.5 clk = ~clk;
  // ----
  // transactions with the reference model
  // ----
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int refuse;
    refuse = (a == 8'h0d || a == 8'h0e) && pw != 8'h7d;
    if (!refuse && a == 8'h0d) r0d = d;
    if (!refuse && a == 8'h0e) r0e = d;
    pw = a == 8'h0b ? d : 0;
    host_model_i.xfer(1'b1, a, d);
    @(posedge clk);
    #1 `chk("refused", reg_write_refused, refuse[0])
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int e;
    e = a == 8'h0b ? pw : a == 8'h0d ? r0d : a == 8'h0e ? r0e : 0;
    if (a == 8'h0c) e = {first_ldo_in_regulation, second_ldo_in_regulation};
    pw = 0;
    host_model_i.xfer(1'b0, a, 8'h00);
    @(posedge clk);
    #1 `chk("rdata", reg_rdata, e[7:0])
  endtask : rd
  task automatic key();
    wr(8'h0b, 8'h7d);
  endtask : key
  // millivolts of a voltage code, from the three step ranges
  function automatic int ref_mv(input int c);
    if (c > 56) return 3300;
    if (c > 52) return 2900 + 100 * (c - 52);
    if (c > 24) return 1500 + 50 * (c - 24);
    return 900 + 25 * c;
  endfunction : ref_mv
  task automatic flags(input logic [1:0] f);
    @(negedge clk);
    {first_ldo_in_regulation, second_ldo_in_regulation} = f;
  endtask : flags
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report();
  end
  initial begin
    void'($urandom(32'h5b98faf6));
    {first_ldo_in_regulation, second_ldo_in_regulation} = 2'b00;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    `chk("oe", power_good_out_oe, 1'b1)
    `chk("pin data", power_good_out, 1'b0)
    foreach (adr[i]) rd(adr[i]);
    $display("test reset values done");
    wr(8'h0d, 8'($urandom));
    wr(8'h0c, 8'hff);
    foreach (keys[i]) begin
      wr(8'h0b, keys[i]);
      wr(8'h0e, 8'($urandom));
    end
    rd(8'h0d);
    rd(8'h0e);
    key();
    wr(8'h0e, 8'($urandom));
    wr(8'h0e, 8'h3f);
    rd(8'h0b);
    key();
    rd(8'h0b);
    key();
    rd(8'h0e);
    rd(8'h0b);
    wr(8'h0e, 8'h00);
    key();
    key();
    wr(8'h0d, 8'h0c);
    rd(8'h0d);
    host_model_i.idle();
    $display("test password lock done");
    for (int i = 0; i < 128; i++) begin
      key();
      wr(8'h0e, {i[6], 1'($urandom), i[5:0]});
      rd(8'h0e);
      host_model_i.idle();
      repeat (3) @(negedge clk);
      `chk("ext", buck_one_external_adjust, r0e[7])
      `chk("code", buck_one_voltage_code, r0e[5:0])
      `chk("mv", buck_one_target_mv, r0e[7] ? 0 : ref_mv(r0e[5:0]))
    end
    $display("test voltage codes done");
    for (int s = 0; s < 4; s++) begin
      flags(2'b00);
      key();
      wr(8'h0d, 8'(s));
      host_model_i.idle();
      lim = 10 << s;
      repeat (3) @(negedge clk);
      `chk("oe held", power_good_out_oe, 1'b1)
      flags(2'b11);
      repeat (lim) @(negedge clk);
      `chk("oe early", power_good_out_oe, 1'b1)
      repeat (1) @(negedge clk);
      `chk("oe late", power_good_out_oe, 1'b0)
      flags(s[0] ? 2'b01 : 2'b10);
      repeat (1) @(negedge clk);
      `chk("oe drop", power_good_out_oe, 1'b1)
      rd(8'h0c);
      host_model_i.idle();
    end
    key();
    wr(8'h0d, 8'h08);
    host_model_i.idle();
    flags(2'b01);
    repeat (15) @(negedge clk);
    `chk("mask first", power_good_out_oe, 1'b0)
    key();
    wr(8'h0d, 8'h04);
    host_model_i.idle();
    repeat (3) @(negedge clk);
    `chk("unmask first", power_good_out_oe, 1'b1)
    flags(2'b10);
    repeat (15) @(negedge clk);
    `chk("mask second", power_good_out_oe, 1'b0)
    $display("test power good done");
    final_report();
  end
endmodule : tb_power_good_and_buck1_config
